/* design/smat_pkg.sv */
/*
 * smat_pkg: constants shared by the strobe memory address translator.
 * Assumes a single 10 MHz clock domain and classic Wishbone register access.
 */
package smat_pkg;
   localparam int unsigned CLK_MHZ = 10;
   localparam int unsigned LADDR_W = 24;
   localparam int unsigned BADDR_W = 26;
   localparam int unsigned DATA_W = 32;
   localparam int unsigned LANES = 4;
   localparam int unsigned CNT_W = 4;
   localparam int unsigned WB_ADR_W = 8;

   // register byte offsets
   localparam logic [7:0] REG_BANK0_CTRL = 8'h00;
   localparam logic [7:0] REG_BANK1_CTRL = 8'h04;
   localparam logic [7:0] REG_IO_CTRL = 8'h08;
   localparam logic [7:0] REG_STATUS = 8'h0c;

   // bank control fields
   localparam int unsigned CF_WIDTH_LO = 0;
   localparam int unsigned CF_SIZE_LO = 2;
   localparam int unsigned CF_WAIT_LO = 4;
   localparam int unsigned CF_SIGN = 7;
   localparam int unsigned CF_W = 8;
   localparam int unsigned WAIT_W = 3;

   // status fields
   localparam int unsigned SF_BUSY = 0;
   localparam int unsigned SF_PROGRAM_WIDTH_SELECT_PIN = 1;
   localparam int unsigned SF_RSP = 2;

   // width and size field encodings (10 is treated as 32 bits)
   localparam logic [1:0] FMT_8 = 2'b00;
   localparam logic [1:0] FMT_16 = 2'b01;
   localparam logic [1:0] FMT_32 = 2'b11;

   // log2 of bytes
   localparam logic [1:0] LG_8 = 2'd0;
   localparam logic [1:0] LG_16 = 2'd1;
   localparam logic [1:0] LG_32 = 2'd2;

   localparam logic [CF_W-1:0] BANK_CTRL_RST = 8'hff;
   localparam logic [WAIT_W-1:0] IO_WAIT_RST = 3'h7;

   // extra cycles that read data spend in the pin synchroniser
   localparam logic [CNT_W-1:0] SYNC_LAT = 4'h2;

   localparam logic [1:0] SPACE_BANK0 = 2'b00;
   localparam logic [1:0] SPACE_BANK1 = 2'b01;

   typedef enum logic [1:0] {
      SMAT_IDLE = 2'b00,
      SMAT_STROBE = 2'b01,
      SMAT_RECOVER = 2'b11,
      SMAT_RESP = 2'b10
   } smat_state_e;
endpackage

/* design/smat_buf.sv */
/*
 * smat_buf: two-entry read data buffer with valid and ready on both sides.
 * Assumes producer and consumer share clk_i; all outputs come from flops.
 */
`timescale 1ns/1ps
`default_nettype none
module smat_buf
   import smat_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [smat_pkg::DATA_W-1:0] in_data_i,
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [smat_pkg::DATA_W-1:0] out_data_o
);
   typedef struct packed {
      logic [DATA_W-1:0] mem0;
      logic [DATA_W-1:0] mem1;
      logic [1:0] cnt;
      logic rd;
      logic wr;
      logic in_ready;
      logic out_valid;
      logic [DATA_W-1:0] out_data;
   } smat_buf_s;

   smat_buf_s q, d;
   logic push, pop;

   always_comb begin
      d = q;
      push = in_valid_i & q.in_ready;
      pop = q.out_valid & out_ready_i;
      if (push) begin
         if (q.wr) begin
            d.mem1 = in_data_i;
         end else begin
            d.mem0 = in_data_i;
         end
         d.wr = ~q.wr;
      end
      if (pop) begin
         d.rd = ~q.rd;
      end
      d.cnt = q.cnt + {1'b0, push} - {1'b0, pop};
      d.out_valid = (d.cnt != 2'd0);
      d.out_data = d.rd ? d.mem1 : d.mem0;
      // ready drops only when both slots hold data, so a stall loses nothing
      d.in_ready = (d.cnt != 2'd2);
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         q <= '0;
         q.in_ready <= 1'b1;
      end else begin
         q <= d;
      end
   end

   assign in_ready_o = q.in_ready;
   assign out_valid_o = q.out_valid;
   assign out_data_o = q.out_data;
endmodule // smat_buf
`default_nettype wire

/* design/smat_top.sv */
/*
 * smat_top: logical to physical address translation and strobe generation
 * for two configurable strobe spaces and a fixed 32-bit I/O space.
 * Assumes a core request port on clk_i, asynchronous memories on the pins,
 * and a classic Wishbone master for the control registers.
 */
// Behaviour
// - 32-bit data in 32-bit memory: physical address equals logical address.
// - I/O space moves 32-bit data with untranslated addresses; fetches there follow the width pin.
// - width field 11 selects 32-bit-wide memory for that space.
// - 32-bit memory: shift address right two for bytes, one for halves.
// - halves in 32-bit memory: logical LSB picks the half word.
// - bytes in 32-bit memory: two low logical bits pick the lane.
// - each bank has four lane strobes; I/O space has one strobe.
// - narrow memory turns lane 3 (and lane 2 for 8-bit) into low address.
// - those extra address pins follow logical address and data size.
// - size equal to narrow width: logical bit zero lands on A-1 or A-2.
// - 32-bit write to 16-bit memory: two cycles, consecutive addresses.
// - 16-bit access to 8-bit memory: two bus cycles, one byte each.
// - multi-cycle accesses step an extra low address bit each cycle.
// - programmed wait states stretch each bus cycle of a space.
// - narrow reads are sign or zero extended; writes are truncated.
// - fetches ignore registers: width pin high means 16-bit, low 32-bit.
// - bytes in 16-bit memory: logical bit zero picks lane 1 or 0.
`timescale 1ns/1ps
`default_nettype none
module smat_top
   import smat_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [smat_pkg::WB_ADR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [smat_pkg::DATA_W-1:0] wb_dat_i,
   output logic [smat_pkg::DATA_W-1:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic req_valid_i,
   output logic req_ready_o,
   input wire logic req_we_i,
   input wire logic req_fetch_i,
   input wire logic [1:0] req_space_i,
   input wire logic [smat_pkg::LADDR_W-1:0] req_addr_i,
   input wire logic [smat_pkg::DATA_W-1:0] req_wdata_i,
   output logic rsp_valid_o,
   input wire logic rsp_ready_i,
   output logic [smat_pkg::DATA_W-1:0] rsp_data_o,
   output logic [smat_pkg::LADDR_W-1:0] mem_addr_o,
   output logic [smat_pkg::DATA_W-1:0] mem_data_o,
   output logic mem_data_oe_n_o,
   input wire logic [smat_pkg::DATA_W-1:0] mem_data_i,
   output logic mem_we_n_o,
   output logic [smat_pkg::LANES-1:0] first_bank_strobe_n_o,
   output logic [smat_pkg::LANES-1:0] second_bank_strobe_n_o,
   output logic io_space_strobe_n_o,
   input wire logic program_width_select_pin_i
);
   typedef struct packed {
      smat_state_e state;
      logic ack;
      logic [DATA_W-1:0] wbdat;
      logic [CF_W-1:0] ctrl0;
      logic [CF_W-1:0] ctrl1;
      logic [WAIT_W-1:0] io_wait;
      logic program_width_select_pin_s1;
      logic program_width_select_pin_s2;
      logic [DATA_W-1:0] din_s1;
      logic [DATA_W-1:0] din_s2;
      logic req_ready;
      logic we;
      logic sgn;
      logic [1:0] space;
      logic [1:0] szl;
      logic [1:0] wdl;
      logic [BADDR_W-1:0] base;
      logic [1:0] k;
      logic [1:0] klast;
      logic [CNT_W-1:0] len;
      logic [CNT_W-1:0] cnt;
      logic [DATA_W-1:0] wdata;
      logic [DATA_W-1:0] acc;
      logic push_valid;
      logic [LADDR_W-1:0] addr;
      logic [DATA_W-1:0] dout;
      logic doe_n;
      logic we_n;
      logic [LANES-1:0] s0;
      logic [LANES-1:0] s1;
      logic sio;
   } smat_top_s;

   smat_top_s q, d;
   logic buf_in_ready;

   // field encoding to log2 bytes; 11 means 32 bits
   function automatic logic [1:0] smat_lg(input logic [1:0] f);
      logic [1:0] r;
      r = LG_32;
      if (f == FMT_8) begin
         r = LG_8;
      end else if (f == FMT_16) begin
         r = LG_16;
      end
      return r;
   endfunction

   function automatic logic [DATA_W-1:0] smat_mask(input logic [1:0] lg);
      logic [DATA_W-1:0] m;
      m = 32'hffffffff;
      if (lg == LG_8) begin
         m = 32'h000000ff;
      end else if (lg == LG_16) begin
         m = 32'h0000ffff;
      end
      return m;
   endfunction

   function automatic logic [CF_W-1:0] smat_wr_ctrl(input logic [CF_W-1:0] old, input logic [DATA_W-1:0] dat,
                                                 input logic [3:0] sel);
      logic [CF_W-1:0] r;
      r = sel[0] ? dat[CF_W-1:0] : old;
      return r;
   endfunction

   logic [1:0] nl, lb, eff_w;
   logic [BADDR_W-1:0] bk;
   logic [4:0] sh;
   logic [LANES-1:0] lanes;
   logic [DATA_W-1:0] chunk, ext;
   logic [CF_W-1:0] sctl;
   logic wb_req;

   always_comb begin
      d = q;
      nl = LG_8;
      lb = 2'd0;
      eff_w = LG_32;
      bk = '0;
      sh = '0;
      lanes = '0;
      chunk = '0;
      ext = '0;
      sctl = q.ctrl0;
      wb_req = wb_cyc_i & wb_stb_i;

      // input pins pass two flops before use
      d.program_width_select_pin_s1 = program_width_select_pin_i;
      d.program_width_select_pin_s2 = q.program_width_select_pin_s1;
      d.din_s1 = mem_data_i;
      d.din_s2 = q.din_s1;

      // wishbone slave: one wait cycle, write lands on the ack edge
      d.ack = wb_req & ~q.ack;
      if (wb_req & ~q.ack) begin
         d.wbdat = '0;
         if (wb_adr_i == REG_BANK0_CTRL) begin
            d.wbdat[CF_W-1:0] = q.ctrl0;
         end else if (wb_adr_i == REG_BANK1_CTRL) begin
            d.wbdat[CF_W-1:0] = q.ctrl1;
         end else if (wb_adr_i == REG_IO_CTRL) begin
            d.wbdat[CF_WAIT_LO +: WAIT_W] = q.io_wait;
         end else if (wb_adr_i == REG_STATUS) begin
            d.wbdat[SF_BUSY] = (q.state != SMAT_IDLE);
            d.wbdat[SF_PROGRAM_WIDTH_SELECT_PIN] = q.program_width_select_pin_s2;
            d.wbdat[SF_RSP] = rsp_valid_o;
         end
      end
      if (wb_req & q.ack & wb_we_i) begin
         if (wb_adr_i == REG_BANK0_CTRL) begin
            d.ctrl0 = smat_wr_ctrl(q.ctrl0, wb_dat_i, wb_sel_i);
         end else if (wb_adr_i == REG_BANK1_CTRL) begin
            d.ctrl1 = smat_wr_ctrl(q.ctrl1, wb_dat_i, wb_sel_i);
         end else if (wb_adr_i == REG_IO_CTRL) begin
            if (wb_sel_i[0]) begin
               d.io_wait = wb_dat_i[CF_WAIT_LO +: WAIT_W];
            end
         end
      end

      case (q.state)
         SMAT_IDLE: begin
            if (req_valid_i & q.req_ready) begin
               sctl = (req_space_i == SPACE_BANK1) ? q.ctrl1 : q.ctrl0;
               d.we = req_we_i;
               d.space = req_space_i;
               d.wdata = req_wdata_i;
               d.acc = '0;
               d.k = 2'd0;
               if (req_fetch_i) begin
                  // fetch width comes from the pin, never from the registers
                  d.szl = LG_32;
                  d.wdl = q.program_width_select_pin_s2 ? LG_16 : LG_32;
                  d.len = '0;
                  d.sgn = 1'b0;
               end else if (req_space_i[1]) begin
                  d.szl = LG_32;
                  d.wdl = LG_32;
                  d.len = {1'b0, q.io_wait};
                  d.sgn = 1'b0;
               end else begin
                  d.szl = smat_lg(sctl[CF_SIZE_LO +: 2]);
                  d.wdl = smat_lg(sctl[CF_WIDTH_LO +: 2]);
                  d.len = {1'b0, sctl[CF_WAIT_LO +: WAIT_W]};
                  d.sgn = sctl[CF_SIGN];
               end
               // byte address: logical address scaled by the data size
               d.base = {2'b00, req_addr_i} << d.szl;
               // oversized data takes 2 or 4 bus cycles
               d.klast = (d.szl > d.wdl) ? 2'((4'd1 << (d.szl - d.wdl)) - 4'd1) : 2'd0;
               if (!req_we_i) begin
                  d.len = d.len + SYNC_LAT;
               end
               d.cnt = d.len;
               d.state = SMAT_STROBE;
            end
         end
         SMAT_STROBE: begin
            if (q.cnt == '0) begin
               if (!q.we) begin
                  // gather this cycle's bytes from their lanes into place
                  bk = q.base + BADDR_W'({q.k, 2'b00} >> (LG_32 - q.wdl));
                  lb = bk[1:0] & 2'((3'd1 << q.wdl) - 3'd1);
                  nl = (q.szl < q.wdl) ? q.szl : q.wdl;
                  sh = 5'({q.k, 3'b000} << q.wdl);
                  chunk = ((q.din_s2 >> {lb, 3'b000}) & smat_mask(nl)) << sh;
                  d.acc = q.acc | chunk;
               end
               d.state = SMAT_RECOVER;
            end else begin
               d.cnt = q.cnt - 4'd1;
            end
         end
         SMAT_RECOVER: begin
            if (q.k == q.klast) begin
               if (q.we) begin
                  d.state = SMAT_IDLE;
               end else begin
                  // narrow reads widen here
                  ext = q.acc & smat_mask(q.szl);
                  if (q.sgn && q.szl == LG_8 && q.acc[7]) begin
                     ext = ext | ~smat_mask(LG_8);
                  end else if (q.sgn && q.szl == LG_16 && q.acc[15]) begin
                     ext = ext | ~smat_mask(LG_16);
                  end
                  d.acc = ext;
                  d.state = SMAT_RESP;
               end
            end else begin
               d.k = q.k + 2'd1;
               d.cnt = q.len;
               d.state = SMAT_STROBE;
            end
         end
         SMAT_RESP: begin
            // holds here while the buffer is full, stalling new requests
            if (q.push_valid & buf_in_ready) begin
               d.state = SMAT_IDLE;
            end
         end
         default: begin
            d.state = SMAT_IDLE;
         end
      endcase

      d.push_valid = (d.state == SMAT_RESP) & ~(q.push_valid & buf_in_ready);
      d.req_ready = (d.state == SMAT_IDLE);

      // pin image of the next cycle, so every pin leaves a flop
      bk = d.base + BADDR_W'({d.k, 2'b00} >> (LG_32 - d.wdl));
      lb = bk[1:0] & 2'((3'd1 << d.wdl) - 3'd1);
      nl = (d.szl < d.wdl) ? d.szl : d.wdl;
      sh = 5'({d.k, 3'b000} << d.wdl);
      lanes = '0;
      if (d.state == SMAT_STROBE) begin
         lanes = 4'(4'((5'd1 << (3'd1 << nl)) - 5'd1) << lb);
      end
      d.addr = bk[BADDR_W-1:2];
      // write data truncated to the size, then steered onto its lanes
      d.dout = ((d.wdata & smat_mask(d.szl)) >> sh) << {lb, 3'b000};
      d.doe_n = ~(d.we & (d.state == SMAT_STROBE || d.state == SMAT_RECOVER));
      d.we_n = ~(d.we & (d.state == SMAT_STROBE));
      d.sio = ~((d.state == SMAT_STROBE) & d.space[1]);
      d.s0 = (d.space == SPACE_BANK0 && !d.space[1]) ? ~lanes : 4'hf;
      d.s1 = (d.space == SPACE_BANK1) ? ~lanes : 4'hf;
      // spare lanes of a narrow bank carry byte address bits 1 and 0
      eff_w = (d.space == SPACE_BANK0) ? d.wdl : smat_lg(d.ctrl0[CF_WIDTH_LO +: 2]);
      if (eff_w != LG_32) begin
         d.s0[3] = bk[1];
      end
      if (eff_w == LG_8) begin
         d.s0[2] = bk[0];
      end
      eff_w = (d.space == SPACE_BANK1) ? d.wdl : smat_lg(d.ctrl1[CF_WIDTH_LO +: 2]);
      if (eff_w != LG_32) begin
         d.s1[3] = bk[1];
      end
      if (eff_w == LG_8) begin
         d.s1[2] = bk[0];
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         q <= '0;
         q.state <= SMAT_IDLE;
         q.ctrl0 <= BANK_CTRL_RST;
         q.ctrl1 <= BANK_CTRL_RST;
         q.io_wait <= IO_WAIT_RST;
         q.szl <= LG_32;
         q.wdl <= LG_32;
         q.doe_n <= 1'b1;
         q.we_n <= 1'b1;
         q.s0 <= 4'hf;
         q.s1 <= 4'hf;
         q.sio <= 1'b1;
      end else begin
         q <= d;
      end
   end

   // the buffer lets the core stall reads without losing a word
   smat_buf u_buf (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .in_valid_i(q.push_valid),
      .in_ready_o(buf_in_ready),
      .in_data_i(q.acc),
      .out_valid_o(rsp_valid_o),
      .out_ready_i(rsp_ready_i),
      .out_data_o(rsp_data_o)
   );

   assign wb_dat_o = q.wbdat;
   assign wb_ack_o = q.ack;
   assign req_ready_o = q.req_ready;
   assign mem_addr_o = q.addr;
   assign mem_data_o = q.dout;
   assign mem_data_oe_n_o = q.doe_n;
   assign mem_we_n_o = q.we_n;
   assign first_bank_strobe_n_o = q.s0;
   assign second_bank_strobe_n_o = q.s1;
   assign io_space_strobe_n_o = q.sio;
endmodule // smat_top
`default_nettype wire

/* dv/smat_top_properties.sv */
/* smat_top_properties: pin timing checks for the translator.
   Assumes it is bound to smat_top and sees only its ports. */
`timescale 1ns/1ps
`default_nettype none
module smat_top_properties
   import smat_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_ack_o,
   input wire logic req_valid_i,
   input wire logic req_ready_o,
   input wire logic rsp_valid_o,
   input wire logic rsp_ready_i,
   input wire logic [smat_pkg::DATA_W-1:0] rsp_data_o,
   input wire logic [smat_pkg::LADDR_W-1:0] mem_addr_o,
   input wire logic mem_data_oe_n_o,
   input wire logic mem_we_n_o,
   input wire logic [smat_pkg::LANES-1:0] first_bank_strobe_n_o,
   input wire logic [smat_pkg::LANES-1:0] second_bank_strobe_n_o,
   input wire logic io_space_strobe_n_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   wire logic io_w = !io_space_strobe_n_o;
   // repurposed lanes may sit low, so "some strobe low" is only a weak busy test
   wire logic any_w = io_w || !(&first_bank_strobe_n_o) || !(&second_bank_strobe_n_o);

   chk_ack_one_pulse: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
      else $error("register ack is not one pulse one cycle after request");
   chk_io_lanes_quiet: assert property (io_w |-> (&first_bank_strobe_n_o[1:0]) && (&second_bank_strobe_n_o[1:0]))
      else $error("bank lane strobe low during io access");
   chk_bank_excl: assert property (!first_bank_strobe_n_o[0] |-> second_bank_strobe_n_o[0] && !io_w)
      else $error("two spaces strobed at once");
   chk_io_addr_hold: assert property (io_w && $past(io_w) |-> $stable(mem_addr_o))
      else $error("address moved inside io strobe");
   chk_write_drives: assert property (!mem_we_n_o |-> !mem_data_oe_n_o)
      else $error("write without driving the data bus");
   chk_take_busy: assert property (req_valid_i && req_ready_o |=> !req_ready_o ##1 !req_ready_o)
      else $error("ready back before strobe and recover");
   chk_take_starts: assert property (req_valid_i && req_ready_o |=> any_w)
      else $error("no strobe one cycle after request taken");
   chk_io_recover: assert property ($rose(io_space_strobe_n_o) |-> !req_ready_o ##1 io_space_strobe_n_o)
      else $error("io recover cycle missing");
   chk_rsp_hold: assert property (rsp_valid_o && !rsp_ready_i |=> rsp_valid_o && $stable(rsp_data_o))
      else $error("stalled read data lost");

   cover property (io_w ##1 !io_w);
   cover property (rsp_valid_o && !rsp_ready_i);
   cover property ($rose(mem_we_n_o) ##[1:3] $fell(mem_we_n_o));
endmodule // smat_top_properties
`default_nettype wire

/* dv/smat_mem_model.sv */
/* smat_mem_model: word-wide asynchronous memory behind the strobes.
   Assumes the bench folds the active space's lane strobes into sel_n_i. */
`timescale 1ns/1ps
`default_nettype none
module smat_mem_model (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [23:0] addr_i,
   input wire logic [31:0] wdata_i,
   input wire logic we_n_i,
   input wire logic [3:0] sel_n_i,
   output logic [31:0] rdata_o
);
   logic [31:0] mem_q [256];
   logic [31:0] last_q;
   // a released bus shows a changing pattern, never the last word
   assign rdata_o = (sel_n_i != 4'hf && we_n_i) ? mem_q[addr_i[7:0]] : ~last_q;
   always_ff @(posedge clk_i) begin
      last_q <= rst_i ? 32'h0 : rdata_o;
   end
   always_ff @(posedge clk_i) begin
      for (int i = 0; i < 4; i++) begin
         if (!sel_n_i[i] && !we_n_i) begin
            mem_q[addr_i[7:0]][8*i+:8] <= wdata_i[8*i+:8];
         end
      end
   end
endmodule // smat_mem_model
`default_nettype wire

/* dv/tb_top.sv */
/* tb_top: random and corner transfers through smat_top against a memory model.
   Assumes one 10 MHz clock and the register map of smat_pkg. */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import smat_pkg::*;
   logic clk_i = 1'b0, rst_i = 1'b1, wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0, wb_ack;
   logic [7:0] wb_adr = 8'h00;
   logic [31:0] wb_wd = 32'h0, wb_rd, req_wd = 32'h0, rsp_data, mem_wd, mem_rd;
   logic req_valid = 1'b0, req_ready, req_we = 1'b0, req_f = 1'b0, rsp_valid, rsp_ready = 1'b0;
   logic [1:0] req_sp = 2'b00;
   logic [23:0] req_a = 24'h0, mem_addr;
   logic mem_oe_n, mem_we_n, io_n, pin = 1'b0, stall = 1'b0, act_q = 1'b0;
   logic [3:0] s0, s1, lane_m = 4'hf;
   logic [31:0] c_dat [4];
   logic [23:0] c_addr [4];
   logic [3:0] c_strb [4];
   int c_len [4];
   int n_cyc = 0, n_fail = 0, num_checks = 0, cycles = 0;
   logic [31:0] exp_q [$];
   wire logic [3:0] sel_n = req_sp[1] ? {4{io_n}} : ((req_sp[0] ? s1 : s0) | ~lane_m);
   wire logic act = sel_n != 4'hf;

   always #50 clk_i = ~clk_i;

   smat_top DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
      .wb_adr_i(wb_adr), .wb_sel_i(4'hf), .wb_dat_i(wb_wd), .wb_dat_o(wb_rd), .wb_ack_o(wb_ack),
      .req_valid_i(req_valid), .req_ready_o(req_ready), .req_we_i(req_we), .req_fetch_i(req_f),
      .req_space_i(req_sp), .req_addr_i(req_a), .req_wdata_i(req_wd), .rsp_valid_o(rsp_valid),
      .rsp_ready_i(rsp_ready), .rsp_data_o(rsp_data), .mem_addr_o(mem_addr), .mem_data_o(mem_wd),
      .mem_data_oe_n_o(mem_oe_n), .mem_data_i(mem_rd), .mem_we_n_o(mem_we_n),
      .first_bank_strobe_n_o(s0), .second_bank_strobe_n_o(s1), .io_space_strobe_n_o(io_n),
      .program_width_select_pin_i(pin));

   smat_mem_model mem (.clk_i(clk_i), .rst_i(rst_i), .addr_i(mem_addr), .wdata_i(mem_wd),
      .we_n_i(mem_we_n), .sel_n_i(sel_n), .rdata_o(mem_rd));

   task automatic check(string what, logic [31:0] exp, logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   // bus cycles are recorded mid-cycle, where registered pins have settled
   always @(negedge clk_i) begin
      if (act && !act_q && n_cyc < 4) begin
         c_addr[n_cyc] = mem_addr;
         c_strb[n_cyc] = req_sp[1] ? {3'b000, io_n} : (req_sp[0] ? s1 : s0);
         c_dat[n_cyc] = mem_wd;
         c_len[n_cyc] = 0;
         n_cyc++;
      end
      if (act && n_cyc > 0) c_len[n_cyc-1]++;
      act_q = act;
      if (rsp_valid && rsp_ready) check("read data", exp_q.pop_front(), rsp_data);
      cycles++;
      if (cycles == 40000) begin
         n_fail++;
         report_and_stop();
      end
   end

   always @(posedge clk_i) rsp_ready <= !stall && ($urandom_range(0, 3) != 0);

   task automatic wb(input logic we, input logic [7:0] ad, input logic [31:0] d, output logic [31:0] q);
      int t = 0;
      @(posedge clk_i);
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we <= we;
      wb_adr <= ad;
      wb_wd <= d;
      do @(posedge clk_i); while (wb_ack !== 1'b1 && t++ < 20);
      if (wb_ack !== 1'b1) n_fail++;
      q = wb_rd;
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
   endtask

   function automatic logic [1:0] enc(int lg);
      return lg == 2 ? FMT_32 : 2'(lg);
   endfunction

   function automatic logic [31:0] ext(logic [31:0] d, int s, logic sg);
      if (s == 0) return {{24{sg & d[7]}}, d[7:0]};
      if (s == 1) return {{16{sg & d[15]}}, d[15:0]};
      return d;
   endfunction

   // w and s are log2 of bytes; expected pins follow from the byte address
   task automatic xfer(int w, int s, int wt, logic [1:0] sp, logic we, logic f, logic [23:0] a,
                       logic [31:0] d, logic [31:0] ex);
      logic [25:0] bk;
      logic [31:0] q, mk;
      logic [3:0] m, ln;
      int n, c, st, t;
      n = (s > w) ? 1 << (s - w) : 1;
      c = 1 << ((s < w) ? s : w);
      m = 4'((1 << (1 << w)) - 1);
      mk = 32'((64'h1 << (8 * c)) - 1);
      t = 0;
      if (!f && !sp[1]) wb(1'b1, sp[0] ? REG_BANK1_CTRL : REG_BANK0_CTRL, {24'h0, a[23], 3'(wt), enc(s), enc(w)}, q);
      if (!we) exp_q.push_back(ex);
      @(posedge clk_i);
      req_valid <= 1'b1;
      req_we <= we;
      req_f <= f;
      req_sp <= sp;
      req_a <= a;
      req_wd <= d;
      lane_m <= m;
      do @(negedge clk_i); while (req_ready !== 1'b1 && t++ < 300);
      @(posedge clk_i);
      req_valid <= 1'b0;
      n_cyc = 0;
      t = 0;
      do @(negedge clk_i); while (req_ready !== 1'b1 && t++ < 60);
      check("bus cycles", 32'(n), 32'(n_cyc));
      for (int k = 0; k < n; k++) begin
         bk = (26'(a) << s) + 26'(k * c);
         st = int'(bk[1:0]) & ((1 << w) - 1);
         ln = 4'(((1 << c) - 1) << st);
         check("address", {8'h0, bk[25:2]}, {8'h0, c_addr[k]});
         check("strobes", {28'h0, ~ln & m}, {28'h0, c_strb[k] & m});
         check("strobe length", 32'(wt + (we ? 1 : 3)), 32'(c_len[k]));
         if (!f && !sp[1] && w < 2) check("low address", {30'h0, bk[1], w == 0 ? bk[0] : 1'b1}, {30'h0, c_strb[k][3:2]});
         if (we) check("write data", (d >> (8 * c * k)) & mk, (c_dat[k] >> (8 * st)) & mk);
      end
   endtask

   initial begin
      logic [31:0] q, d;
      logic [23:0] a;
      void'($urandom(66256));
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      wb(1'b0, REG_BANK0_CTRL, 32'h0, q);
      check("bank0 reset", {24'h0, BANK_CTRL_RST}, q);
      wb(1'b0, REG_BANK1_CTRL, 32'h0, q);
      check("bank1 reset", {24'h0, BANK_CTRL_RST}, q);
      wb(1'b1, 8'h40, 32'hffffffff, q);
      wb(1'b0, 8'h40, 32'h0, q);
      check("unmapped read", 32'h0, q);
      $display("test registers done");
      // every width and size pair, first pass at the top logical address
      for (int r = 0; r < 6; r++) begin
         for (int w = 0; w < 3; w++) begin
            for (int s = 0; s < 3; s++) begin
               a = (r == 0) ? 24'hffffff : 24'($urandom);
               d = $urandom;
               xfer(w, s, r % 4, {1'b0, r[0]}, 1'b1, 1'b0, a, d, 32'h0);
               if (w == 2) xfer(w, s, r % 4, {1'b0, r[0]}, 1'b0, 1'b0, a, d, ext(d, s, a[23]));
            end
         end
         xfer(2, 2, int'(IO_WAIT_RST), 2'b10, 1'b1, 1'b0, a, d, 32'h0);
         xfer(2, 2, int'(IO_WAIT_RST), 2'b10, 1'b0, 1'b0, a, d, d);
      end
      $display("test table done");
      a = 24'($urandom);
      d = $urandom;
      xfer(2, 2, 0, 2'b00, 1'b1, 1'b0, a, d, 32'h0);
      @(posedge clk_i) pin <= 1'b1;
      repeat (4) @(posedge clk_i);
      xfer(1, 2, 0, 2'b00, 1'b0, 1'b1, a, d, {d[15:0], d[15:0]});
      @(posedge clk_i) pin <= 1'b0;
      repeat (4) @(posedge clk_i);
      xfer(2, 2, 0, 2'b01, 1'b0, 1'b1, a, d, d);
      $display("test fetch done");
      repeat (20) @(negedge clk_i);
      stall = 1'b1;
      for (int k = 0; k < 3; k++) xfer(2, 2, 0, 2'b01, 1'b0, 1'b0, a, d, d);
      repeat (5) @(negedge clk_i);
      check("refused while full", 32'h1, {31'h0, rsp_valid & !req_ready});
      stall = 1'b0;
      xfer(2, 2, 0, 2'b01, 1'b0, 1'b0, a, d, d);
      repeat (40) @(negedge clk_i);
      check("responses left", 32'h0, 32'(exp_q.size()));
      $display("test buffer done");
      report_and_stop();
   end
endmodule // tb_top

bind smat_top smat_top_properties chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .req_valid_i(req_valid_i), .req_ready_o(req_ready_o),
   .rsp_valid_o(rsp_valid_o), .rsp_ready_i(rsp_ready_i), .rsp_data_o(rsp_data_o),
   .mem_addr_o(mem_addr_o), .mem_data_oe_n_o(mem_data_oe_n_o), .mem_we_n_o(mem_we_n_o),
   .first_bank_strobe_n_o(first_bank_strobe_n_o), .second_bank_strobe_n_o(second_bank_strobe_n_o),
   .io_space_strobe_n_o(io_space_strobe_n_o));
`default_nettype wire
